// ### pmsc_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module pmsc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // read side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic full;
  logic empty;
  assign full = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty = wrPtr_q == rdPtr_q;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule : pmsc_fifo

// ### pmsc_host_model.sv
// housekeeping controller model driving the serial pins
`timescale 1ns/1ps
module pmsc_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic shiftClk,
  output logic serialIn,
  output logic registerLoad,
  output logic testLoad,
  input wire logic serialOut
);
  initial begin
    shiftClk = 1'b0;
    serialIn = 1'b0;
    registerLoad = 1'b0;
    testLoad = 1'b0;
  end
  // one half of the 80 ns shift clock
  task automatic half(input int n);
    repeat (n * 4) @(negedge clk);
  endtask : half
  // bit 0 first so bit 47 lands last; data sampled before each shift
  task automatic shiftOut(input logic [47:0] d, output logic [47:0] got);
    for (int i = 0; i < 48; i++) begin
      serialIn = d[i];
      got[i] = serialOut;
      half(1);
      shiftClk = 1'b1;
      half(1);
      shiftClk = 1'b0;
    end
    serialIn = ~d[47];
  endtask : shiftOut
  task automatic load(input logic tl, input logic on);
    if (tl) testLoad = on;
    else registerLoad = on;
    half(2);
  endtask : load
  task automatic pulse(input logic tl);
    load(tl, 1'b1);
    load(tl, 1'b0);
  endtask : pulse
endmodule : pmsc_host_model

// ### pmsc_pkg.sv
// constants and shared types for the serial control sequencer
// What this block does
// - 48-bit shift register fed from serial input, msb arrives last.
// - test select low gives normal mode, control registers only.
// - after 48 bits parity shows on serial out; register load latches data only if parity is even.
// - normal mode feeds stored eeprom contents to configuration users.
// - test select high gives test mode with access to everything.
// - unchecked access loads registers without parity, shows shift data.
// - bits 47..45 select test operation 0 to 7.
// - ops 0,2,3,5 copy a source into shift register on test load.
// - captured protection states clear when power request rises.
// - ops 1 and 4 stage eeprom data; staged data then overrides.
// - op 6 writes user eeprom, op 7 writes trimming eeprom.
// - at power-up only boost runs; on ready it leaves wake-up for skip.
// - internal logic reset when ready is released, clearing status.
// - power request rise gives pwm; regulators wait 544 pwm pulses.
// - third channel starts first; its soft start done enables the rest.
// - falling edge of system power-down disables all channels at once.
// - controller-off channel stays off until on; off stops it at once.
// - without controller, all channels start with default register values.
// - boost stays in skip while power request is low.
// - backup-charge regulator held off about 30 us after ready.
// - usb regulator held off 1.03 ms after ready.
package pmsc_pkg;
  localparam int SR_W = 48;
  localparam int OP_HI = 47;
  localparam int OP_LO = 45;
  localparam logic [2:0] OP_RD_CTRL = 3'h0;
  localparam logic [2:0] OP_STG_USER = 3'h1;
  localparam logic [2:0] OP_RD_USER = 3'h2;
  localparam logic [2:0] OP_RD_PROT = 3'h3;
  localparam logic [2:0] OP_STG_TRIM = 3'h4;
  localparam logic [2:0] OP_RD_TRIM = 3'h5;
  localparam logic [2:0] OP_WR_USER = 3'h6;
  localparam logic [2:0] OP_WR_TRIM = 3'h7;
  localparam int CLK_MHZ = 100;
  localparam int BACKUP_DLY_NS = 30000;
  localparam int USB_DLY_NS = 1030000;
  localparam int BACKUP_DLY_CYC = BACKUP_DLY_NS * CLK_MHZ / 1000;
  localparam int USB_DLY_CYC = USB_DLY_NS * CLK_MHZ / 1000;
  localparam int PWM_HOLD_PULSES = 544;
  localparam int PWM_DIV_DEF = 200;
  localparam logic [47:0] CTRL_RESET = 48'hFFFF_FFFF_FFFF;
  typedef enum logic [2:0] {
    SEQ_WAKE, SEQ_SKIP, SEQ_HOLD, SEQ_SOFT3, SEQ_RUN
  } pmsc_seq_e;
endpackage : pmsc_pkg

// ### pmsc_props.sv
// assertions on the sequencer and eeprom strobes of pmsc_top
`timescale 1ns/1ps
module pmsc_props
  import pmsc_pkg::*;
#(
  parameter int USB_DLY = USB_DLY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic testSelect,
  input wire logic ready,
  input wire logic hostPowerRequest,
  input wire logic systemPowerDownSignal,
  // outputs
  input wire logic [47:0] ctrlRegs,
  input wire logic userRomWrite,
  input wire logic trimRomWrite,
  input wire logic boostWake,
  input wire logic boostPwm,
  input wire logic thirdChannelEnable,
  input wire logic othersEnable,
  input wire logic backupChargeRegulatorEnable,
  input wire logic usbLinearRegulatorEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // counts from the pin, so it leads the design's synced view
  int readyCnt_q;
  always_ff @(posedge clk) begin
    if (rst || !ready) readyCnt_q <= 0;
    else if (readyCnt_q < 2000000) readyCnt_q <= readyCnt_q + 1;
  end
  property p_wake; !(boostWake && boostPwm); endproperty
  a_wake: assert property (p_wake)
    else $error("wake and pwm together");
  property p_skip; $fell(hostPowerRequest) |-> ##[1:6] !boostPwm; endproperty
  a_skip: assert property (p_skip)
    else $error("pwm kept after power request low");
  property p_pwm;
    $rose(hostPowerRequest) && !boostWake |-> ##[1:6] boostPwm;
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("no pwm after power request");
  property p_hold; $rose(boostPwm) |-> !thirdChannelEnable [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("third channel early");
  property p_order; $rose(othersEnable) |-> boostPwm; endproperty
  a_order: assert property (p_order)
    else $error("others on without pwm");
  property p_down;
    $fell(systemPowerDownSignal) |-> ##[1:6]
      !(thirdChannelEnable || othersEnable);
  endproperty
  a_down: assert property (p_down)
    else $error("channels on after power down");
  property p_rst; $fell(ready) |-> ##[1:6] ctrlRegs == CTRL_RESET; endproperty
  a_rst: assert property (p_rst)
    else $error("no internal reset on ready loss");
  property p_rom;
    (userRomWrite || trimRomWrite) |->
      testSelect && !(userRomWrite && trimRomWrite);
  endproperty
  a_rom: assert property (p_rom)
    else $error("bad eeprom write strobe");
  property p_backup;
    $rose(backupChargeRegulatorEnable) |-> readyCnt_q >= BACKUP_DLY_CYC;
  endproperty
  a_backup: assert property (p_backup)
    else $error("backup regulator early");
  property p_usb; $rose(usbLinearRegulatorEnable) |-> readyCnt_q >= USB_DLY;
  endproperty
  a_usb: assert property (p_usb)
    else $error("usb regulator early");
  c_run: cover property ($rose(othersEnable));
  c_down: cover property ($fell(systemPowerDownSignal));
  c_rom: cover property ($rose(userRomWrite));
endmodule : pmsc_props

bind pmsc_top pmsc_props #(.USB_DLY(USB_DLY)) i_props (
  .clk(clk), .rst(rst), .testSelect(testSelect), .ready(ready),
  .hostPowerRequest(hostPowerRequest), .ctrlRegs(ctrlRegs),
  .systemPowerDownSignal(systemPowerDownSignal),
  .userRomWrite(userRomWrite), .trimRomWrite(trimRomWrite),
  .boostWake(boostWake), .boostPwm(boostPwm),
  .thirdChannelEnable(thirdChannelEnable), .othersEnable(othersEnable),
  .backupChargeRegulatorEnable(backupChargeRegulatorEnable),
  .usbLinearRegulatorEnable(usbLinearRegulatorEnable));

// ### pmsc_top.sv
// serial control interface, test operations and power-up enable sequencer
`timescale 1ns/1ps
module pmsc_top
  import pmsc_pkg::*;
#(
  parameter int USB_DLY = USB_DLY_CYC,
  parameter int PWM_DIV = PWM_DIV_DEF,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins (asynchronous)
  input wire logic serialIn,
  input wire logic shiftClk,
  input wire logic registerLoad,
  input wire logic testLoad,
  input wire logic testSelect,
  output logic serialOut,
  // power control pins (asynchronous)
  input wire logic ready,
  input wire logic hostPowerRequest,
  input wire logic softStartDone,
  input wire logic systemPowerDownSignal,
  input wire logic [47:0] protState,
  input wire logic [47:0] userRomStored,
  input wire logic [47:0] trimRomStored,
  // eeprom write and configuration outputs
  output logic userRomWrite,
  output logic trimRomWrite,
  output logic [47:0] romWriteData,
  output logic [47:0] userConfig,
  output logic [47:0] trimConfig,
  output logic [47:0] ctrlRegs,
  // sequencer outputs and parity fail flag
  output logic boostWake,
  output logic boostPwm,
  output logic regulatorGroupEnable,
  output logic thirdChannelEnable,
  output logic othersEnable,
  output logic backupChargeRegulatorEnable,
  output logic usbLinearRegulatorEnable,
  output logic parityFail
);
  // two-flop synchronisers for the nine single-bit pin inputs, one generate loop
  localparam int NS = 9;
  logic [NS-1:0] pinRaw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] syncPrev_q;
  assign pinRaw = {serialIn, shiftClk, registerLoad, testLoad, testSelect,
                   ready, hostPowerRequest, softStartDone,
                   systemPowerDownSignal};
  genvar gi;
  for (gi = 0; gi < NS; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (rst) begin
        sync1_q[gi] <= 1'b0;
        sync2_q[gi] <= 1'b0;
        syncPrev_q[gi] <= 1'b0;
      end else begin
        sync1_q[gi] <= pinRaw[gi];
        sync2_q[gi] <= sync1_q[gi];
        syncPrev_q[gi] <= sync2_q[gi];
      end
    end
  end
  logic sIn, sTest, sReady, sPwr, sSs3;
  logic shiftRise, ldRise, tldRise, tldLevel;
  logic readyRise, readyFall, pwrRise, pwrLow, sddFall;
  assign sIn = sync2_q[8];
  assign shiftRise = sync2_q[7] && !syncPrev_q[7];
  assign ldRise = sync2_q[6] && !syncPrev_q[6];
  assign tldRise = sync2_q[5] && !syncPrev_q[5];
  assign tldLevel = sync2_q[5];
  assign sTest = sync2_q[4];
  assign sReady = sync2_q[3];
  assign readyRise = sync2_q[3] && !syncPrev_q[3];
  assign readyFall = !sync2_q[3] && syncPrev_q[3];
  assign sPwr = sync2_q[2];
  assign pwrRise = sync2_q[2] && !syncPrev_q[2];
  assign pwrLow = !sPwr;
  assign sSs3 = sync2_q[1];
  assign sddFall = !sync2_q[0] && syncPrev_q[0];

  // internal logic reset pulse when ready is released
  logic logicRst;
  assign logicRst = rst || readyFall;

  // shift register and test operation decode
  logic [SR_W-1:0] shift_q;
  logic [2:0] op;
  logic parityOk;
  logic userStaged_q, trimStaged_q;
  logic [47:0] userStage_q, trimStage_q, protCap_q;
  assign op = shift_q[OP_HI:OP_LO];
  assign parityOk = sTest || !(^shift_q);
  // fifo decouples accepted frames from the control register writer
  logic fifoInReady, fifoOutValid;
  logic [47:0] fifoOutData;
  logic frameLoad;
  assign frameLoad = ldRise && parityOk && fifoInReady;
  pmsc_fifo #(.WIDTH(SR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(logicRst),
    .inValid(frameLoad),
    .inReady(fifoInReady),
    .inData(shift_q),
    .outValid(fifoOutValid),
    .outReady(!tldLevel),
    .outData(fifoOutData)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= '0;
    end else if (sTest && tldRise && (op == OP_RD_CTRL)) begin
      shift_q <= ctrlRegs;
    end else if (sTest && tldRise && (op == OP_RD_USER)) begin
      shift_q <= userConfig;
    end else if (sTest && tldRise && (op == OP_RD_PROT)) begin
      shift_q <= protCap_q;
    end else if (sTest && tldRise && (op == OP_RD_TRIM)) begin
      shift_q <= trimConfig;
    end else if (shiftRise) begin
      shift_q <= {sIn, shift_q[SR_W-1:1]};
    end
  end
  // control registers: defaults serve the no-controller case
  always_ff @(posedge clk) begin
    if (logicRst) begin
      ctrlRegs <= CTRL_RESET;
    end else if (fifoOutValid && !tldLevel) begin
      ctrlRegs <= fifoOutData;
    end
  end
  // staging registers and eeprom write strobes
  always_ff @(posedge clk) begin
    if (rst || !sTest) begin
      userStaged_q <= 1'b0;
      trimStaged_q <= 1'b0;
      userStage_q <= '0;
      trimStage_q <= '0;
    end else if (tldRise && op == OP_STG_USER) begin
      userStaged_q <= 1'b1;
      userStage_q <= shift_q;
    end else if (tldRise && op == OP_STG_TRIM) begin
      trimStaged_q <= 1'b1;
      trimStage_q <= shift_q;
    end
  end
  // write lasts as long as test load is held
  always_ff @(posedge clk) begin
    if (rst) begin
      userRomWrite <= 1'b0;
      trimRomWrite <= 1'b0;
      romWriteData <= '0;
    end else begin
      userRomWrite <= sTest && tldLevel && op == OP_WR_USER;
      trimRomWrite <= sTest && tldLevel && op == OP_WR_TRIM;
      romWriteData <= (op == OP_WR_TRIM) ? trimStage_q : userStage_q;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      userConfig <= '0;
      trimConfig <= '0;
    end else begin
      userConfig <= userStaged_q ? userStage_q : userRomStored;
      trimConfig <= trimStaged_q ? trimStage_q : trimRomStored;
    end
  end
  // protection flags come from another domain, so they pass two flops
  logic [47:0] protSync1_q, protSync2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      protSync1_q <= '0;
      protSync2_q <= '0;
    end else begin
      protSync1_q <= protState;
      protSync2_q <= protSync1_q;
    end
  end
  // protection capture: sticky; an event in the clear cycle is kept
  always_ff @(posedge clk) begin
    if (logicRst) begin
      protCap_q <= '0;
    end else if (pwrRise) begin
      protCap_q <= protSync2_q;
    end else begin
      protCap_q <= protCap_q | protSync2_q;
    end
  end
  // serial out: registered here, so no glitch despite caution
  always_ff @(posedge clk) begin
    if (rst) begin
      serialOut <= 1'b0;
      parityFail <= 1'b0;
    end else begin
      serialOut <= sTest ? shift_q[0] : parityOk;
      parityFail <= !parityOk;
    end
  end

  // pwm pulse divider and power-up sequencer
  localparam int DW = $clog2(PWM_DIV + 1);
  // the ready counter must reach the longer of the two regulator delays
  localparam int RC_MAX = (USB_DLY > BACKUP_DLY_CYC) ? USB_DLY :
                          BACKUP_DLY_CYC;
  localparam int UW = $clog2(RC_MAX + 1);
  logic [DW-1:0] div_q;
  logic pwmTick;
  logic [9:0] pulses_q;
  logic [UW-1:0] readyCnt_q;
  logic [2:0] chOff;
  pmsc_seq_e seq_q;
  assign pwmTick = div_q == DW'(PWM_DIV - 1);
  always_ff @(posedge clk) begin
    if (rst || pwmTick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (logicRst) begin
      seq_q <= SEQ_WAKE;
      pulses_q <= '0;
    end else begin
      case (seq_q)
        SEQ_WAKE: begin
          if (readyRise) begin
            seq_q <= SEQ_SKIP;
          end
        end
        SEQ_SKIP: begin
          pulses_q <= '0;
          if (pwrRise) begin
            seq_q <= SEQ_HOLD;
          end
        end
        SEQ_HOLD: begin
          if (pwrLow || sddFall) begin
            seq_q <= SEQ_SKIP;
          end else if (pulses_q == 10'(PWM_HOLD_PULSES)) begin
            seq_q <= SEQ_SOFT3;
          end else if (pwmTick) begin
            pulses_q <= pulses_q + 1'b1;
          end
        end
        SEQ_SOFT3: begin
          if (pwrLow || sddFall) begin
            seq_q <= SEQ_SKIP;
          end else if (sSs3) begin
            seq_q <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (pwrLow || sddFall) begin
            seq_q <= SEQ_SKIP;
          end
        end
        default: seq_q <= SEQ_WAKE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (logicRst || !sReady) begin
      readyCnt_q <= '0;
    end else if (readyCnt_q != UW'(RC_MAX)) begin
      readyCnt_q <= readyCnt_q + 1'b1;
    end
  end
  // ctrlRegs bits 2..0 gate channel groups; a cleared bit stops at once
  assign chOff = ~ctrlRegs[2:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      boostWake <= 1'b1;
      boostPwm <= 1'b0;
      regulatorGroupEnable <= 1'b0;
      thirdChannelEnable <= 1'b0;
      othersEnable <= 1'b0;
      backupChargeRegulatorEnable <= 1'b0;
      usbLinearRegulatorEnable <= 1'b0;
    end else begin
      boostWake <= seq_q == SEQ_WAKE;
      boostPwm <= seq_q != SEQ_WAKE && seq_q != SEQ_SKIP;
      regulatorGroupEnable <= seq_q != SEQ_WAKE;
      thirdChannelEnable <= (seq_q == SEQ_SOFT3 || seq_q == SEQ_RUN) &&
                            !chOff[0];
      othersEnable <= seq_q == SEQ_RUN && !chOff[1];
      backupChargeRegulatorEnable <= seq_q != SEQ_WAKE && !chOff[2] &&
        readyCnt_q >= UW'(BACKUP_DLY_CYC);
      usbLinearRegulatorEnable <= seq_q != SEQ_WAKE &&
        readyCnt_q >= UW'(USB_DLY);
    end
  end
endmodule : pmsc_top

// ### pmsc_top_tb.sv
// testbench for pmsc_top with the host model on the serial pins
`timescale 1ns/1ps
module pmsc_top_tb;
  import pmsc_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic testSelect;
  logic ready;
  logic hostPowerRequest;
  logic softStartDone;
  logic systemPowerDownSignal;
  logic [47:0] protState;
  logic [47:0] userRomStored;
  logic [47:0] trimRomStored;
  logic shiftClk, serialIn, registerLoad, testLoad, serialOut, parityFail;
  logic userRomWrite, trimRomWrite, boostWake, boostPwm, groupEn;
  logic thirdChannelEnable, othersEnable, backupEn, usbEn;
  logic [47:0] romWriteData, userConfig, trimConfig, ctrlRegs, seen;
  int errTotal = 0;
  int checkCount = 0;
  always #5 clk = ~clk;
  pmsc_top #(.USB_DLY(200), .PWM_DIV(2), .FIFO_DEPTH(32)) i_dut (
    .clk(clk), .rst(rst), .serialIn(serialIn), .shiftClk(shiftClk),
    .registerLoad(registerLoad), .testLoad(testLoad),
    .testSelect(testSelect), .serialOut(serialOut), .ready(ready),
    .hostPowerRequest(hostPowerRequest), .softStartDone(softStartDone),
    .systemPowerDownSignal(systemPowerDownSignal), .protState(protState),
    .userRomStored(userRomStored), .trimRomStored(trimRomStored),
    .userRomWrite(userRomWrite), .trimRomWrite(trimRomWrite),
    .romWriteData(romWriteData), .userConfig(userConfig),
    .trimConfig(trimConfig), .ctrlRegs(ctrlRegs), .boostWake(boostWake),
    .boostPwm(boostPwm), .regulatorGroupEnable(groupEn),
    .thirdChannelEnable(thirdChannelEnable), .othersEnable(othersEnable),
    .backupChargeRegulatorEnable(backupEn),
    .usbLinearRegulatorEnable(usbEn), .parityFail(parityFail));
  pmsc_host_model i_host (
    .clk(clk), .shiftClk(shiftClk), .serialIn(serialIn),
    .registerLoad(registerLoad), .testLoad(testLoad), .serialOut(serialOut));
  task automatic wrapUp();
    if (errTotal == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrapUp
  task automatic chk(input string nm, input logic [47:0] exp, got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic waitHi(ref logic s, input int n, input string nm);
    for (int i = 0; i < n && s !== 1'b1; i++) cyc(1);
    if (s !== 1'b1) begin
      chk(nm, 48'h1, {47'h0, s});
      wrapUp();
    end
  endtask : waitHi
  task automatic readOp(input logic [2:0] op);
    i_host.shiftOut({op, 45'h0}, seen);
    i_host.pulse(1'b1);
    i_host.shiftOut(48'h0, seen);
  endtask : readOp
  task automatic t_boot();
    chk("ctrlRegs", CTRL_RESET, ctrlRegs);
    chk("boostWake", 1, boostWake);
    chk("groupEn", 0, groupEn);
    ready = 1'b1;
    cyc(190);
    chk("boostWake", 0, boostWake);
    chk("groupEn", 1, groupEn);
    chk("usb", 0, usbEn);
    cyc(60);
    chk("usb", 1, usbEn);
    cyc(2700);
    chk("backup", 0, backupEn);
    waitHi(backupEn, 300, "backup");
  endtask : t_boot
  task automatic t_normal();
    i_host.shiftOut(48'h0000_0000_000F, seen);
    cyc(8);
    chk("serialOut", 1, serialOut);
    chk("userConfig", userRomStored, userConfig);
    i_host.pulse(1'b0);
    chk("ctrlRegs", 48'h0000_0000_000F, ctrlRegs);
    i_host.shiftOut(48'h0000_0000_0007, seen);
    cyc(8);
    chk("serialOut", 0, serialOut);
    i_host.pulse(1'b0);
    chk("parityFail", 1, parityFail);
    chk("ctrlRegs", 48'h0000_0000_000F, ctrlRegs);
  endtask : t_normal
  task automatic t_test();
    logic [47:0] src [4];
    logic [2:0] op [4];
    logic [47:0] d;
    testSelect = 1'b1;
    src = '{48'h0001_0000_0107, userRomStored, protState, trimRomStored};
    op = '{OP_RD_CTRL, OP_RD_USER, OP_RD_PROT, OP_RD_TRIM};
    i_host.shiftOut(src[0], seen);
    i_host.pulse(1'b0);
    chk("ctrlRegs", src[0], ctrlRegs);
    for (int k = 0; k < 4; k++) begin
      readOp(op[k]);
      chk("readback", src[k], seen);
    end
    for (int j = 0; j < 2; j++) begin
      d = {j ? OP_STG_TRIM : OP_STG_USER, 45'h0ABC};
      i_host.shiftOut(d, seen);
      i_host.pulse(1'b1);
      chk("staged", d, j ? trimConfig : userConfig);
      i_host.shiftOut({j ? OP_WR_TRIM : OP_WR_USER, 45'h0}, seen);
      i_host.load(1'b1, 1'b1);
      chk("romWrite", 1, j ? trimRomWrite : userRomWrite);
      chk("romData", d, romWriteData);
      i_host.load(1'b1, 1'b0);
      chk("romWrite", 0, j ? trimRomWrite : userRomWrite);
    end
  endtask : t_test
  task automatic t_seq();
    protState = 48'h0;
    chk("boostPwm", 0, boostPwm);
    hostPowerRequest = 1'b1;
    cyc(10);
    chk("boostPwm", 1, boostPwm);
    cyc(990);
    chk("third", 0, thirdChannelEnable);
    waitHi(thirdChannelEnable, 200, "third");
    chk("others", 0, othersEnable);
    softStartDone = 1'b1;
    waitHi(othersEnable, 10, "others");
    readOp(OP_RD_PROT);
    chk("prot", 48'h0, seen);
  endtask : t_seq
  task automatic t_off();
    testSelect = 1'b0;
    i_host.shiftOut(48'h0000_0000_0006, seen);
    i_host.pulse(1'b0);
    chk("third", 0, thirdChannelEnable);
    chk("others", 1, othersEnable);
    trimRomStored = 48'h7777_8888_9999;
    cyc(8);
    chk("trimConfig", trimRomStored, trimConfig);
    systemPowerDownSignal = 1'b0;
    cyc(8);
    chk("others", 0, othersEnable);
    hostPowerRequest = 1'b0;
    cyc(8);
    systemPowerDownSignal = 1'b1;
    hostPowerRequest = 1'b1;
    cyc(10);
    chk("boostPwm", 1, boostPwm);
    hostPowerRequest = 1'b0;
    cyc(8);
    chk("boostPwm", 0, boostPwm);
    ready = 1'b0;
    cyc(8);
    chk("ctrlRegs", CTRL_RESET, ctrlRegs);
  endtask : t_off
  initial begin
    rst = 1'b1;
    testSelect = 1'b0;
    ready = 1'b0;
    hostPowerRequest = 1'b0;
    softStartDone = 1'b0;
    systemPowerDownSignal = 1'b1;
    protState = 48'h0000_0000_00A5;
    userRomStored = 48'h1111_2222_3333;
    trimRomStored = 48'h4444_5555_6666;
    cyc(12);
    rst = 1'b0;
    cyc(4);
    t_boot();
    t_normal();
    t_test();
    t_seq();
    t_off();
    wrapUp();
  end
endmodule : pmsc_top_tb
